// [hdl/drive_select_pkg.sv]
package drive_select_pkg;
   localparam int          REG_ADDR_WIDTH      = 2;
   localparam int          REG_DATA_WIDTH      = 8;
   localparam int          LEVEL_WIDTH         = 2;
   localparam int          PIN_COUNT           = 8;
   // register indices
   localparam logic [1:0]  ADDR_PORTS_A_B      = 2'h0;
   localparam logic [1:0]  ADDR_SECOND         = 2'h1;
   localparam logic [1:0]  ADDR_PORTS_E_F      = 2'h2;
   localparam logic [1:0]  ADDR_PORT_G         = 2'h3;
   // field positions (low bit of each two-bit field)
   localparam int          POS_HIGH            = 6;
   localparam int          POS_UPPER_MID       = 4;
   localparam int          POS_LOWER_MID       = 2;
   localparam int          POS_LOW             = 0;
   // reset values and masks
   localparam logic [7:0]  RESET_DRIVE         = 8'h00;
   localparam logic [7:0]  MASK_FULL           = 8'hFF;
   localparam logic [7:0]  MASK_PORT_G         = 8'h03;
   // direction bit meaning
   localparam logic        DIR_OUTPUT          = 1'b0;
   localparam logic [1:0]  LEVEL_WEAKEST       = 2'h0;

   typedef enum logic [1:0] {
      LEVEL_0,
      LEVEL_1,
      LEVEL_2,
      LEVEL_3
   } drive_level_type;

   function automatic logic [1:0] field_of(input logic [7:0] value, input int pos);
      logic [7:0] shifted;
      shifted = value >> pos;
      return shifted[1:0];
   endfunction
endpackage

// [hdl/drive_regs_if.sv]
`timescale 1ns/10ps
interface drive_regs_if;
   logic [7:0] ports_a_b;
   logic [7:0] second;
   logic [7:0] ports_e_f;
   logic [7:0] port_g;
   modport owner (output ports_a_b, second, ports_e_f, port_g);
   modport user  (input  ports_a_b, second, ports_e_f, port_g);
endinterface

// [hdl/drive_regs.sv]
`timescale 1ns/10ps
module drive_regs
   import drive_select_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   drive_regs_if.owner     regs
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regs.ports_a_b <= RESET_DRIVE;
         regs.second    <= RESET_DRIVE;
         regs.ports_e_f <= RESET_DRIVE;
         regs.port_g    <= RESET_DRIVE;
      end else if (wr) begin
         case (addr)
            ADDR_PORTS_A_B: regs.ports_a_b <= wdata & MASK_FULL;
            ADDR_SECOND:    regs.second    <= wdata & MASK_FULL;
            ADDR_PORTS_E_F: regs.ports_e_f <= wdata & MASK_FULL;
            ADDR_PORT_G:    regs.port_g    <= wdata & MASK_PORT_G;
            default: ;
         endcase
      end
   end

   // read data held only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            ADDR_PORTS_A_B: rdata <= regs.ports_a_b;
            ADDR_SECOND:    rdata <= regs.second;
            ADDR_PORTS_E_F: rdata <= regs.ports_e_f;
            ADDR_PORT_G:    rdata <= regs.port_g & MASK_PORT_G;
            default:        rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule

// [hdl/port_drive_strength_select.sv]
`timescale 1ns/10ps
module port_drive_strength_select
   import drive_select_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   input  wire logic [7:0]  porta_dir,
   input  wire logic [7:0]  portb_dir,
   input  wire logic [7:0]  portc_dir,
   input  wire logic [7:0]  porte_dir,
   input  wire logic [7:0]  portf_dir,
   input  wire logic [2:0]  portg_dir,
   output logic      [15:0] porta_drive,
   output logic      [15:0] portb_drive,
   output logic      [15:0] portc_drive,
   output logic      [15:0] porte_drive,
   output logic      [15:0] portf_drive,
   output logic      [5:0]  portg_drive
);
   drive_regs_if regs ();

   logic [1:0] porta_low_nibble_level;
   logic [1:0] porta_high_nibble_level;
   logic [1:0] portb_low_nibble_level;
   logic [1:0] portb_pin7_level;
   logic [1:0] portc_upper_pair_level;
   logic [1:0] porte_low_nibble_level;
   logic [1:0] porte_high_nibble_level;
   logic [1:0] portf_low_nibble_level;
   logic [1:0] portf_high_nibble_level;
   logic [1:0] portg_level;

   drive_regs u_regs (
      .clk   (clk),
      .rst_n (rst_n),
      .addr  (addr),
      .wdata (wdata),
      .wr    (wr),
      .rd    (rd),
      .rdata (rdata),
      .regs  (regs)
   );

   // field decode; levels pass through as the raw two-bit code
   always_comb begin
      portb_pin7_level        = field_of(regs.ports_a_b, POS_HIGH);
      portb_low_nibble_level  = field_of(regs.ports_a_b, POS_UPPER_MID);
      porta_high_nibble_level = field_of(regs.ports_a_b, POS_LOWER_MID);
      porta_low_nibble_level  = field_of(regs.ports_a_b, POS_LOW);
      portc_upper_pair_level  = field_of(regs.second, POS_LOWER_MID);
      portf_high_nibble_level = field_of(regs.ports_e_f, POS_HIGH);
      portf_low_nibble_level  = field_of(regs.ports_e_f, POS_UPPER_MID);
      porte_high_nibble_level = field_of(regs.ports_e_f, POS_LOWER_MID);
      porte_low_nibble_level  = field_of(regs.ports_e_f, POS_LOW);
      portg_level             = field_of(regs.port_g, POS_LOW);
   end

   // level if output, else weakest code (the pad ignores it when input)
   function automatic logic [1:0] gated(input logic dir, input logic [1:0] level);
      drive_level_type decoded;
      decoded = drive_level_type'(level);
      return (dir == DIR_OUTPUT) ? 2'(decoded) : LEVEL_WEAKEST;
   endfunction

   // direction inputs come from port logic on this clock: no synchroniser
   // second register's unmapped fields do not reach any pin
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         porta_drive <= '0;
         portb_drive <= '0;
         portc_drive <= '0;
         porte_drive <= '0;
         portf_drive <= '0;
         portg_drive <= '0;
      end else begin
         for (int i = 0; i < PIN_COUNT; i++) begin
            porta_drive[2*i +: 2] <= gated(porta_dir[i],
               (i < 4) ? porta_low_nibble_level : porta_high_nibble_level);
            portb_drive[2*i +: 2] <= (i == 7) ? gated(portb_dir[i], portb_pin7_level) :
               (i < 4) ? gated(portb_dir[i], portb_low_nibble_level) : LEVEL_WEAKEST;
            portc_drive[2*i +: 2] <= (i == 4 || i == 5) ?
               gated(portc_dir[i], portc_upper_pair_level) : LEVEL_WEAKEST;
            porte_drive[2*i +: 2] <= gated(porte_dir[i],
               (i < 4) ? porte_low_nibble_level : porte_high_nibble_level);
            portf_drive[2*i +: 2] <= gated(portf_dir[i],
               (i < 4) ? portf_low_nibble_level : portf_high_nibble_level);
         end
         for (int j = 0; j < 3; j++) begin
            portg_drive[2*j +: 2] <= gated(portg_dir[j], portg_level);
         end
      end
   end
endmodule

// [verification/port_drive_strength_select_chk.sv]
`timescale 1ns/10ps
module port_drive_strength_select_chk
   import drive_select_pkg::*;
(
   input wire logic        clk, rst_n, wr, rd,
   input wire logic [1:0]  addr,
   input wire logic [7:0]  wdata, rdata, porta_dir, portb_dir,
   input wire logic [2:0]  portg_dir,
   input wire logic [15:0] porta_drive, portb_drive, portc_drive,
   input wire logic [5:0]  portg_drive
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_g_upper_zero: assert property ($past(rd) && $past(addr) == ADDR_PORT_G |-> rdata[7:2] == 6'h00)
      else $error("port g upper bits set");
   a_b7_level: assert property ((wr && addr == ADDR_PORTS_A_B) ##1 (!wr && !portb_dir[7])
      |=> portb_drive[15:14] == $past(wdata[7:6], 2)) else $error("b7 level wrong");
   a_a0_level: assert property ((wr && addr == ADDR_PORTS_A_B) ##1 (!wr && !porta_dir[0])
      |=> porta_drive[1:0] == $past(wdata[1:0], 2)) else $error("a0 level wrong");
   a_a_input_zero: assert property (porta_dir[5] |=> porta_drive[11:10] == 2'h0)
      else $error("input pin driven");
   a_b_input_zero: assert property (portb_dir[7] |=> portb_drive[15:14] == 2'h0)
      else $error("input pin driven");
   a_a_group_same: assert property (porta_dir[7:4] == 4'h0 |=> porta_drive[15:14] == porta_drive[9:8])
      else $error("group split");
   a_g_group_same: assert property (portg_dir == 3'h0 |=> portg_drive[5:4] == portg_drive[1:0])
      else $error("group split");
   a_unused_zero: assert property (portb_drive[13:8] == 6'h00 && portc_drive[7:0] == 8'h00)
      else $error("absent pin driven");
endmodule
bind port_drive_strength_select port_drive_strength_select_chk chk (.clk(clk), .rst_n(rst_n), .wr(wr), .rd(rd),
   .addr(addr), .wdata(wdata), .rdata(rdata), .porta_dir(porta_dir), .portb_dir(portb_dir), .portg_dir(portg_dir),
   .porta_drive(porta_drive), .portb_drive(portb_drive), .portc_drive(portc_drive), .portg_drive(portg_drive));

// [verification/port_drive_strength_select_tb_top.sv]
`timescale 1ns/10ps
module port_drive_strength_select_tb_top
   import drive_select_pkg::*;
;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [1:0]  addr = 2'h0;
   logic [7:0]  wdata = 8'h00, v, rdata;
   logic [7:0]  porta_dir = 8'h00, portb_dir = 8'h00, portc_dir = 8'h00, porte_dir = 8'h00, portf_dir = 8'h00;
   logic [2:0]  portg_dir = 3'h0;
   logic [15:0] porta_drive, portb_drive, portc_drive, porte_drive, portf_drive;
   logic [5:0]  portg_drive;
   int          err_total = 0, n_compared = 0, cyc = 0;
   port_drive_strength_select DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .porta_dir(porta_dir), .portb_dir(portb_dir), .portc_dir(portc_dir), .porte_dir(porte_dir),
      .portf_dir(portf_dir), .portg_dir(portg_dir), .porta_drive(porta_drive), .portb_drive(portb_drive),
      .portc_drive(portc_drive), .porte_drive(porte_drive), .portf_drive(portf_drive), .portg_drive(portg_drive));
   always #2.5 clk = ~clk;
   task automatic results;
      if (err_total == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // generous ceiling: the sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         results();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // gap cycle after each strobe so no signal is assigned twice at one edge
   task automatic put(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic get(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check("rdata", {8'h00, rdata}, {8'h00, exp});
   endtask
   function automatic logic [15:0] gate(input logic [15:0] x, input logic [7:0] dir);
      for (int i = 0; i < 8; i++) if (dir[i]) x[2*i+:2] = 2'h0;
      return x;
   endfunction
   task automatic drives(input logic [7:0] a, input logic [7:0] s, input logic [7:0] e, input logic [7:0] g);
      repeat (2) @(negedge clk);
      check("porta", porta_drive, gate({{4{a[3:2]}}, {4{a[1:0]}}}, porta_dir));
      check("portb", portb_drive, gate({a[7:6], 6'h00, {4{a[5:4]}}}, portb_dir));
      check("portc", portc_drive, gate({4'h0, {2{s[3:2]}}, 8'h00}, portc_dir));
      check("porte", porte_drive, gate({{4{e[3:2]}}, {4{e[1:0]}}}, porte_dir));
      check("portf", portf_drive, gate({{4{e[7:6]}}, {4{e[5:4]}}}, portf_dir));
      check("portg", {10'h000, portg_drive}, gate({10'h000, {3{g[1:0]}}}, {5'h00, portg_dir}));
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) get(2'(i), 8'h00);
      for (int k = 0; k < 4; k++) begin
         v = {2'(k), 2'(k + 1), 2'(k + 2), 2'(k + 3)};
         put(ADDR_PORTS_A_B, v);
         put(ADDR_SECOND, ~v);
         put(ADDR_PORTS_E_F, {v[3:0], v[7:4]});
         put(ADDR_PORT_G, ~v);
         get(ADDR_PORT_G, {6'h00, ~v[1:0]});
         get(ADDR_SECOND, ~v);
         get(ADDR_PORTS_E_F, {v[3:0], v[7:4]});
         drives(v, ~v, {v[3:0], v[7:4]}, ~v);
      end
      @(posedge clk);
      porta_dir <= 8'hF0;
      portb_dir <= 8'h81;
      portc_dir <= 8'h10;
      porte_dir <= 8'h0F;
      portf_dir <= 8'hA5;
      portg_dir <= 3'h5;
      drives(v, ~v, {v[3:0], v[7:4]}, ~v);
      // back-to-back write then read: read must return the new value
      @(posedge clk);
      addr <= ADDR_PORTS_A_B;
      wdata <= 8'h5A;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check("rdata_b2b", {8'h00, rdata}, 16'h005A);
      @(posedge clk);
      rst_n <= 1'b0;
      drives(8'h00, 8'h00, 8'h00, 8'h00);
      @(posedge clk);
      rst_n <= 1'b1;
      get(ADDR_PORTS_A_B, 8'h00);
      results();
   end
endmodule
